/* File: shared/csp_pkg.sv */
// Constants and types shared by the codec serial port cascade block.
package csp_pkg;

  // ****************************************************************
  // Serial word and control word layout
  // ****************************************************************
  localparam int WORD_W     = 16;
  localparam int CW_CTRL    = 15;  // Set marks a control word in mixed mode.
  localparam int CW_READ    = 14;  // Set asks for a register read.
  localparam int CW_ADDR_LO = 11;
  localparam int ADDR_W     = 3;
  localparam int CW_REG_LO  = 8;
  localparam int SEL_W      = 3;
  localparam int DATA_W     = 8;
  localparam int BIT_CNT_W  = 4;
  localparam int FS_CNT_W   = 4;

  localparam logic [BIT_CNT_W-1:0] LAST_BIT     = 4'hf;
  localparam logic [WORD_W-1:0]    INVALID_WORD = 16'h0000;

  // ****************************************************************
  // Control registers
  // ****************************************************************
  localparam logic [SEL_W-1:0] SEL_A = 3'h0;
  localparam logic [SEL_W-1:0] SEL_B = 3'h1;
  localparam logic [SEL_W-1:0] SEL_C = 3'h2;
  localparam logic [SEL_W-1:0] SEL_D = 3'h3;

  localparam int CRA_PDS    = 0;  // program_data_select.
  localparam int CRA_MM     = 1;  // Mixed mode.
  localparam int CRA_CNT_LO = 2;  // Device count minus one.
  localparam int CNT_W      = 3;
  localparam int CRA_CEE    = 5;  // control_echo_enable.
  localparam int CRA_FRAME_SYNC_LOOPBACK   = 6;  // frame_sync_loopback.
  localparam int CRB_DIV_LO = 0;
  localparam int CRB_RATE_LO = 2;
  localparam int CRB_FLD_W  = 2;
  localparam int CRC_PWR    = 0;

  localparam logic [DATA_W-1:0] CRA_RST = 8'h00;
  localparam logic [DATA_W-1:0] CRB_RST = 8'h00;
  localparam logic [DATA_W-1:0] CRC_RST = 8'h00;
  localparam logic [DATA_W-1:0] CRD_RST = 8'h00;

  // ****************************************************************
  // APB map
  // ****************************************************************
  localparam int APB_AW = 12;
  localparam logic [APB_AW-1:0] OFS_CRA    = 12'h000;
  localparam logic [APB_AW-1:0] OFS_CRB    = 12'h004;
  localparam logic [APB_AW-1:0] OFS_CRC    = 12'h008;
  localparam logic [APB_AW-1:0] OFS_CRD    = 12'h00c;
  localparam logic [APB_AW-1:0] OFS_STATUS = 12'h010;
  localparam logic [APB_AW-1:0] OFS_DAC    = 12'h014;

  // ****************************************************************
  // Modes and link states
  // ****************************************************************
  typedef enum logic [1:0] {
    MODE_PROGRAM = 2'b00,
    MODE_DATA    = 2'b01,
    MODE_MIXED   = 2'b10
  } csp_mode_t;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_SYNC  = 2'b01,
    TX_SHIFT = 2'b10
  } csp_tx_t;

  typedef enum logic {
    RX_IDLE  = 1'b0,
    RX_SHIFT = 1'b1
  } csp_rx_t;

endpackage : csp_pkg

/* File: rtl/csp_sclk_gen.sv */
// Serial clock generator: master clock divider and serial clock rate.
`timescale 1ns/1ps
module csp_sclk_gen #(
  parameter int FLD_W = 2
) (
  input  wire logic             clock,
  input  wire logic             arst_n,
  input  wire logic [FLD_W-1:0] div_sel,
  input  wire logic [FLD_W-1:0] rate_sel,
  output logic                  sclk,
  output logic                  bit_tick
);

  localparam int HALF_W = (1 << FLD_W);

  // Wider fields would need a half-period counter far larger than useful.
  if (FLD_W < 1 || FLD_W > 4) begin : g_fld_check
    $error("csp_sclk_gen: FLD_W must lie between 1 and 4");
  end

  logic [FLD_W-1:0]  pre;
  logic [HALF_W-1:0] half;
  logic              dm_tick;
  logic [HALF_W-1:0] half_last;

  // The divided master clock ticks once every div_sel+1 clocks.
  assign dm_tick   = (pre == div_sel);
  // Half a serial clock period is 2^rate divided-clock ticks.
  assign half_last = HALF_W'((1 << rate_sel) - 1);

  // Pre-divider; a smaller new ratio restarts it cleanly.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pre <= '0;
    end else if (pre >= div_sel) begin
      pre <= '0;
    end else begin
      pre <= pre + FLD_W'(1);
    end
  end

  // Serial clock toggles every half period; bit_tick marks its rising edge.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      half     <= '0;
      sclk     <= 1'b0;
      bit_tick <= 1'b0;
    end else begin
      bit_tick <= 1'b0;
      if (dm_tick) begin
        if (half >= half_last) begin
          half     <= '0;
          sclk     <= ~sclk;
          bit_tick <= ~sclk;
        end else begin
          half <= half + HALF_W'(1);
        end
      end
    end
  end

endmodule : csp_sclk_gen

/* File: rtl/csp_serial_port.sv */
// Codec serial port with control word routing, cascade and APB registers.
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
module csp_serial_port
  import csp_pkg::*;
(
  input  wire logic                        CLOCK,
  input  wire logic                        ARST_N,
  input  wire logic [csp_pkg::APB_AW-1:0]  PADDR,
  input  wire logic                        PSEL,
  input  wire logic                        PENABLE,
  input  wire logic                        PWRITE,
  input  wire logic [31:0]                 PWDATA,
  output logic      [31:0]                 PRDATA,
  output logic                             PREADY,
  output logic                             PSLVERR,
  input  wire logic                        SERIAL_IN,
  input  wire logic                        IN_FRAME_SYNC,
  output logic                             SERIAL_OUT,
  output logic                             OUT_FRAME_SYNC,
  output logic                             SCLK,
  input  wire logic                        ADC_STROBE,
  input  wire logic [csp_pkg::WORD_W-1:0]  ADC_DATA,
  output logic      [csp_pkg::WORD_W-1:0]  DAC_DATA,
  output logic                             DAC_LOAD,
  output logic                             SAMPLE_VALID,
  output logic                             ANALOG_POWER,
  output logic      [csp_pkg::DATA_W-1:0]  ENC_GAIN
);

  import csp_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [DATA_W-1:0]    control_reg_a, control_reg_b, crc, control_reg_d;
  logic [WORD_W-1:0]    sr;
  logic [BIT_CNT_W-1:0] rx_cnt, tx_cnt;
  logic [FS_CNT_W-1:0]  fs_cnt;
  csp_rx_t              rx_st;
  csp_tx_t              tx_st;
  csp_mode_t            mode;
  logic                 bit_tick, out_pend;
  logic                 rx_done, is_ctrl, ctl_here, ctl_wr, fwd, dac_hit;
  logic [WORD_W-1:0]    rx_word, fwd_word;
  logic [ADDR_W-1:0]    rx_addr;
  logic [SEL_W-1:0]     rx_sel;
  logic [FS_CNT_W-1:0]  dev_count, next_fs_cnt;
  logic                 apb_wr;

  // ****************************************************************
  // Helper functions
  // ****************************************************************
  // Control register contents by select code; unknown selects read zero.
  function automatic logic [DATA_W-1:0] reg_value(input logic [SEL_W-1:0] sel,
      input logic [DATA_W-1:0] a, input logic [DATA_W-1:0] b,
      input logic [DATA_W-1:0] c, input logic [DATA_W-1:0] d);
    unique case (sel)
      SEL_A:   reg_value = a;
      SEL_B:   reg_value = b;
      SEL_C:   reg_value = c;
      SEL_D:   reg_value = d;
      default: reg_value = '0;
    endcase
  endfunction : reg_value

  // Operating mode follows register A.
  function automatic csp_mode_t mode_of(input logic [DATA_W-1:0] a);
    if (!a[CRA_PDS]) begin
      mode_of = MODE_PROGRAM;
    end else if (a[CRA_MM]) begin
      mode_of = MODE_MIXED;
    end else begin
      mode_of = MODE_DATA;
    end
  endfunction : mode_of

  // ****************************************************************
  // Serial clock
  // ****************************************************************
  // The device makes the serial clock; data moves on its rising edge.
  csp_sclk_gen #(
    .FLD_W    (CRB_FLD_W)
  ) u_sclk (
    .clock    (CLOCK),
    .arst_n   (ARST_N),
    .div_sel  (control_reg_b[CRB_DIV_LO +: CRB_FLD_W]),
    .rate_sel (control_reg_b[CRB_RATE_LO +: CRB_FLD_W]),
    .sclk     (SCLK),
    .bit_tick (bit_tick)
  );

  // ****************************************************************
  // Word decode
  // ****************************************************************
  // The completed word is the shift register with the last bit appended.
  assign rx_done   = bit_tick && (rx_st == RX_SHIFT) && (rx_cnt == LAST_BIT);
  assign rx_word   = {sr[WORD_W-2:0], SERIAL_IN};
  assign rx_addr   = rx_word[CW_ADDR_LO +: ADDR_W];
  assign rx_sel    = rx_word[CW_REG_LO +: SEL_W];
  assign mode      = mode_of(control_reg_a);
  assign dev_count = FS_CNT_W'(control_reg_a[CRA_CNT_LO +: CNT_W]) + FS_CNT_W'(1);
  // Program mode takes every word as control, data mode none of them.
  assign is_ctrl   = (mode == MODE_PROGRAM) ||
                     ((mode == MODE_MIXED) && rx_word[CW_CTRL]);
  assign ctl_here  = rx_done && is_ctrl && (rx_addr == '0);
  assign ctl_wr    = ctl_here && !rx_word[CW_READ];
  assign next_fs_cnt = fs_cnt + FS_CNT_W'(1);
  assign dac_hit   = rx_done && !is_ctrl && (next_fs_cnt == dev_count);

  // Decide whether and what to send on after a word arrives.
  always_comb begin
    fwd      = 1'b0;
    fwd_word = rx_word;
    if (rx_done) begin
      if (is_ctrl && (rx_addr != '0)) begin
        fwd = 1'b1;
        fwd_word[CW_ADDR_LO +: ADDR_W] = rx_addr - ADDR_W'(1);
      end else if (is_ctrl && rx_word[CW_READ]) begin
        fwd = 1'b1;
        fwd_word[DATA_W-1:0] = reg_value(rx_sel, control_reg_a, control_reg_b, crc, control_reg_d);
      end else if (is_ctrl) begin
        fwd = control_reg_a[CRA_CEE];
      end else begin
        fwd = !dac_hit;
      end
    end
  end

  // ****************************************************************
  // Receive framing
  // ****************************************************************
  // A sync seen on the last bit starts the next word back to back.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_st  <= RX_IDLE;
      rx_cnt <= '0;
    end else if (bit_tick) begin
      unique case (rx_st)
        RX_IDLE: begin
          rx_cnt <= '0;
          if (IN_FRAME_SYNC) begin
            rx_st <= RX_SHIFT;
          end
        end
        RX_SHIFT: begin
          rx_cnt <= rx_cnt + BIT_CNT_W'(1);
          if (rx_cnt == LAST_BIT) begin
            rx_st <= IN_FRAME_SYNC ? RX_SHIFT : RX_IDLE;
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Transmit framing
  // ****************************************************************
  // A send request waits until the previous word has left.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      out_pend <= 1'b0;
    end else if (fwd || ADC_STROBE) begin
      out_pend <= 1'b1;  // A new request wins over the clear.
    end else if (bit_tick && (tx_st == TX_IDLE)) begin
      out_pend <= 1'b0;
    end
  end

  // Frame sync stands one bit period ahead of the MSB.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_st          <= TX_IDLE;
      tx_cnt         <= '0;
      OUT_FRAME_SYNC <= 1'b0;
      SERIAL_OUT     <= 1'b0;
    end else if (bit_tick) begin
      unique case (tx_st)
        TX_IDLE: begin
          if (out_pend) begin
            tx_st          <= TX_SYNC;
            OUT_FRAME_SYNC <= 1'b1;
          end
        end
        TX_SYNC: begin
          tx_st          <= TX_SHIFT;
          tx_cnt         <= BIT_CNT_W'(1);  // The MSB leaves as the sync ends.
          OUT_FRAME_SYNC <= 1'b0;
          SERIAL_OUT     <= sr[WORD_W-1];
        end
        TX_SHIFT: begin
          SERIAL_OUT <= sr[WORD_W-1];
          tx_cnt     <= tx_cnt + BIT_CNT_W'(1);
          if (tx_cnt == LAST_BIT) begin
            tx_st <= TX_IDLE;
          end
        end
        default: tx_st <= TX_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Serial register
  // ****************************************************************
  // One register serves both directions, as in a daisy chain: the word
  // going out makes room for the word coming in. A sample event beats a
  // word completing in the same cycle, so that word is lost.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      sr <= INVALID_WORD;
    end else if (ADC_STROBE) begin
      sr <= (mode == MODE_PROGRAM) ? INVALID_WORD : ADC_DATA;
    end else if (rx_done) begin
      sr <= fwd_word;
    end else if (bit_tick && ((rx_st == RX_SHIFT) || (tx_st != TX_IDLE))) begin
      sr <= {sr[WORD_W-2:0], (rx_st == RX_SHIFT) ? SERIAL_IN : 1'b0};
    end
  end

  // Marks whether the last loaded sample is a real converter word.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      SAMPLE_VALID <= 1'b0;
    end else if (ADC_STROBE) begin
      SAMPLE_VALID <= (mode != MODE_PROGRAM);
    end
  end

  // ****************************************************************
  // DAC update by frame sync count
  // ****************************************************************
  // Control words in mixed mode leave the counter alone.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      fs_cnt <= '0;
    end else if (dac_hit) begin
      fs_cnt <= '0;
    end else if (rx_done && !is_ctrl) begin
      fs_cnt <= next_fs_cnt;
    end
  end

  // DAC register loads from the word that met the count.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      DAC_DATA <= '0;
      DAC_LOAD <= 1'b0;
    end else begin
      DAC_LOAD <= dac_hit;
      if (dac_hit) begin
        DAC_DATA <= rx_word;
      end
    end
  end

  // ****************************************************************
  // Control registers
  // ****************************************************************
  assign apb_wr = PSEL && PENABLE && PWRITE;

  // Serial writes take effect at word end, each device on its own word, so a
  // cascade changes device by device; they win over an APB write in the same cycle.
  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      control_reg_a <= CRA_RST;
      control_reg_b <= CRB_RST;
      crc <= CRC_RST;
      control_reg_d <= CRD_RST;
    end else if (ctl_wr) begin
      unique case (rx_sel)
        SEL_A:   control_reg_a <= rx_word[DATA_W-1:0];
        SEL_B:   control_reg_b <= rx_word[DATA_W-1:0];
        SEL_C:   crc <= rx_word[DATA_W-1:0];
        SEL_D:   control_reg_d <= rx_word[DATA_W-1:0];
        default: control_reg_a <= control_reg_a;
      endcase
    end else if (apb_wr) begin
      unique case (PADDR)
        OFS_CRA: control_reg_a <= PWDATA[DATA_W-1:0];
        OFS_CRB: control_reg_b <= PWDATA[DATA_W-1:0];
        OFS_CRC: crc <= PWDATA[DATA_W-1:0];
        OFS_CRD: control_reg_d <= PWDATA[DATA_W-1:0];
        default: control_reg_a <= control_reg_a;
      endcase
    end
  end

  assign ANALOG_POWER = crc[CRC_PWR];
  assign ENC_GAIN     = control_reg_d;

  // ****************************************************************
  // APB slave
  // ****************************************************************
  // Zero wait states; unmapped addresses answer with an error.
  assign PREADY  = 1'b1;
  assign PSLVERR = PSEL && PENABLE && (PADDR > OFS_DAC || PADDR[1:0] != 2'b00);

  always_ff @(posedge CLOCK or negedge ARST_N) begin
    if (!ARST_N) begin
      PRDATA <= '0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      unique case (PADDR)
        OFS_CRA:    PRDATA <= 32'(control_reg_a);
        OFS_CRB:    PRDATA <= 32'(control_reg_b);
        OFS_CRC:    PRDATA <= 32'(crc);
        OFS_CRD:    PRDATA <= 32'(control_reg_d);
        OFS_STATUS: PRDATA <= 32'({SAMPLE_VALID, fs_cnt, mode});
        OFS_DAC:    PRDATA <= 32'(DAC_DATA);
        default:    PRDATA <= '0;
      endcase
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);

  sequence s_sync_lead;
    OUT_FRAME_SYNC && bit_tick;
  endsequence

  sequence s_frame_follows;
    ##[0:70] OUT_FRAME_SYNC;
  endsequence

  a_sync_one_bit: assert property (s_sync_lead |=>
      !OUT_FRAME_SYNC && tx_st == TX_SHIFT && SERIAL_OUT == $past(sr[WORD_W-1]))
    else $error("frame sync not one bit ahead of data");
  a_dac_count_load: assert property (dac_hit |=> DAC_LOAD && DAC_DATA == $past(rx_word))
    else $error("DAC not loaded at device count");
  a_counter_clear: assert property (DAC_LOAD |-> fs_cnt == '0)
    else $error("frame sync counter not cleared");
  a_addr_forward: assert property (rx_done && is_ctrl && rx_addr != '0 && !ADC_STROBE |=>
      sr[CW_ADDR_LO +: ADDR_W] == ADDR_W'($past(rx_addr) - ADDR_W'(1)) ##0 s_frame_follows)
    else $error("control word not decremented and forwarded");
  a_data_no_ctrl: assert property (mode == MODE_DATA && rx_done && !apb_wr |=>
      control_reg_a == $past(control_reg_a) && control_reg_b == $past(control_reg_b))
    else $error("data mode word changed a control register");
  a_adc_sample: assert property (ADC_STROBE && mode != MODE_PROGRAM |=>
      sr == $past(ADC_DATA) ##0 s_frame_follows)
    else $error("sample event did not load and send ADC word");
  a_prog_invalid: assert property (ADC_STROBE && mode == MODE_PROGRAM |=>
      sr == INVALID_WORD && !SAMPLE_VALID)
    else $error("program mode produced a valid sample");
  a_mixed_ctrl_count: assert property (mode == MODE_MIXED && rx_done && rx_word[CW_CTRL] |=>
      $stable(fs_cnt))
    else $error("control word advanced frame sync counter");
  a_write_same_frame: assert property (ctl_wr && rx_sel == SEL_A |=>
      control_reg_a == $past(rx_word[DATA_W-1:0]))
    else $error("addressed write not applied at word end");

endmodule : csp_serial_port

/* File: testbench/csp_host_model.sv */
// Host serial port model: sends queued words and collects returned words.
`timescale 1ns/1ps
module csp_host_model (
  input  wire logic sclk,
  input  wire logic arst_n,
  input  wire logic serial_out,
  input  wire logic out_frame_sync,
  output logic      serial_in,
  output logic      in_frame_sync
);
  logic [15:0] tx_q[$];
  logic [15:0] rx_q[$];
  logic [15:0] sh;
  logic [15:0] rsh;
  logic [4:0]  cnt;
  logic [4:0]  rcnt;

  // Words leave in queue order, farthest device first, with no gap.
  // Only the host raises the input sync, one bit before the MSB.
  // Between words the data line toggles so a stale bit cannot pass as data.
  always @(negedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 5'h00;
      in_frame_sync <= 1'b0;
      serial_in <= 1'b0;
    end else begin
      if (cnt != 5'h00) begin
        serial_in <= sh[cnt-5'h01];
      end else begin
        serial_in <= ~serial_in;
      end
      if ((cnt <= 5'h01) && (tx_q.size() != 0)) begin
        in_frame_sync <= 1'b1;
        sh <= tx_q.pop_front();
        cnt <= 5'h10;
      end else begin
        in_frame_sync <= 1'b0;
        cnt <= (cnt != 5'h00) ? cnt - 5'h01 : cnt;
      end
    end
  end

  // Returned words are taken on the rising serial clock, MSB first.
  always @(posedge sclk or negedge arst_n) begin
    if (!arst_n) begin
      rcnt <= 5'h00;
    end else if (rcnt != 5'h00) begin
      rsh <= {rsh[14:0], serial_out};
      rcnt <= rcnt - 5'h01;
      if (rcnt == 5'h01) begin
        rx_q.push_back({rsh[14:0], serial_out});
      end
    end else if (out_frame_sync) begin
      rcnt <= 5'h10;
    end
  end
endmodule : csp_host_model

/* File: testbench/testbench.sv */
// Self-checking bench for the codec serial port against a host model.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", nm, e, s); end end
module testbench;
  import csp_pkg::*;
  logic        CLOCK = 1'b0, ARST_N = 1'b0, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
  logic        ADC_STROBE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, PRDATA, rd;
  logic [15:0] ADC_DATA = 16'h0000, DAC_DATA;
  logic [7:0]  ENC_GAIN;
  logic        PREADY, PSLVERR, SERIAL_IN, IN_FRAME_SYNC, SERIAL_OUT, OUT_FRAME_SYNC, SCLK;
  logic        DAC_LOAD, SAMPLE_VALID, ANALOG_POWER, err;
  int          fail_count = 0, checks_done = 0, loads = 0;

  csp_serial_port uut (.CLOCK, .ARST_N, .PADDR, .PSEL, .PENABLE, .PWRITE, .PWDATA, .PRDATA,
    .PREADY, .PSLVERR, .SERIAL_IN, .IN_FRAME_SYNC, .SERIAL_OUT, .OUT_FRAME_SYNC, .SCLK,
    .ADC_STROBE, .ADC_DATA, .DAC_DATA, .DAC_LOAD, .SAMPLE_VALID, .ANALOG_POWER, .ENC_GAIN);
  csp_host_model host (.sclk(SCLK), .arst_n(ARST_N), .serial_out(SERIAL_OUT),
    .out_frame_sync(OUT_FRAME_SYNC), .serial_in(SERIAL_IN), .in_frame_sync(IN_FRAME_SYNC));

  // Free-running 200 MHz clock and a count of DAC load pulses.
  always #2.5 CLOCK = ~CLOCK;
  always @(posedge CLOCK) if (DAC_LOAD === 1'b1) loads++;

  function automatic logic [15:0] cw(input logic r, input logic [2:0] ad,
                                     input logic [2:0] sel, input logic [7:0] d);
    return {1'b1, r, ad, sel, d};
  endfunction : cw

  // APB cycle; the request is held until PREADY is seen high at an edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLOCK);
    end while (PREADY !== 1'b1);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    // Outputs fed by the write settle after this edge; callers look later.
    @(negedge CLOCK);
  endtask : apb

  // Hand one word to the host and wait until it has left the line.
  task automatic send(input logic [15:0] w);
    int n;
    host.tx_q.push_back(w);
    for (n = 0; n < 500 && (host.tx_q.size() != 0 || host.cnt != 5'h00); n++) @(posedge CLOCK);
    repeat (8) @(posedge CLOCK);
  endtask : send

  task automatic get(input int k);
    int n;
    for (n = 0; n < 800 && host.rx_q.size() < k; n++) @(posedge CLOCK);
    `CHK("words back", k, host.rx_q.size())
  endtask : get

  task automatic adc(input logic [15:0] d);
    host.rx_q.delete();
    @(posedge CLOCK);
    ADC_STROBE <= 1'b1;
    ADC_DATA <= d;
    @(posedge CLOCK);
    ADC_STROBE <= 1'b0;
    get(1);
  endtask : adc

  task automatic t_reset;
    logic [11:0] ofs[5] = '{OFS_CRA, OFS_CRB, OFS_CRC, OFS_CRD, OFS_STATUS};
    foreach (ofs[i]) begin
      apb(1'b0, ofs[i], 32'h0);
      `CHK("reset value", 32'h0, rd)
    end
    apb(1'b1, OFS_DAC, 32'hffff);
    apb(1'b0, OFS_DAC, 32'h0);
    `CHK("dac read only", 32'h0, rd)
    apb(1'b0, 12'h018, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
  endtask : t_reset

  task automatic t_regs;
    time t0;
    apb(1'b1, OFS_CRC, 32'h01);
    `CHK("power", 1'b1, ANALOG_POWER)
    apb(1'b1, OFS_CRD, 32'h5a);
    `CHK("gain", 8'h5a, ENC_GAIN)
    apb(1'b1, OFS_CRB, 32'h01);
    repeat (3) @(posedge SCLK);
    t0 = $time;
    @(posedge SCLK);
    `CHK("sclk period", 20, int'($time - t0))
    apb(1'b1, OFS_CRB, 32'h00);
    repeat (3) @(posedge SCLK);
  endtask : t_regs

  task automatic t_program;
    host.rx_q.delete();
    send(cw(1'b0, 3'h2, SEL_D, 8'h77));
    get(1);
    `CHK("forwarded", cw(1'b0, 3'h1, SEL_D, 8'h77), host.rx_q[0])
    `CHK("gain kept", 8'h5a, ENC_GAIN)
    send(cw(1'b0, 3'h0, SEL_D, 8'h33));
    `CHK("serial gain", 8'h33, ENC_GAIN)
    host.rx_q.delete();
    send(cw(1'b1, 3'h0, SEL_D, 8'h00));
    get(1);
    `CHK("read reply", cw(1'b1, 3'h0, SEL_D, 8'h33), host.rx_q[0])
    adc(16'h1234);
    `CHK("program sample", INVALID_WORD, host.rx_q[0])
    `CHK("sample flag", 1'b0, SAMPLE_VALID)
  endtask : t_program

  task automatic t_mixed;
    int l;
    send(cw(1'b0, 3'h0, SEL_A, 8'h03));
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("mixed mode", MODE_MIXED, rd[1:0])
    l = loads;
    send(16'h1357);
    `CHK("mixed dac", 16'h1357, DAC_DATA)
    `CHK("mixed load", l + 1, loads)
    send(cw(1'b0, 3'h0, SEL_D, 8'h44));
    `CHK("mixed ctrl", 8'h44, ENC_GAIN)
    `CHK("ctrl no load", l + 1, loads)
    host.rx_q.delete();
    send(cw(1'b1, 3'h0, SEL_D, 8'h00));
    get(1);
    `CHK("mixed read", cw(1'b1, 3'h0, SEL_D, 8'h44), host.rx_q[0])
    `CHK("read no load", l + 1, loads)
  endtask : t_mixed

  task automatic t_data;
    int l;
    apb(1'b1, OFS_CRA, 32'h05);
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("data mode", MODE_DATA, rd[1:0])
    host.rx_q.delete();
    l = loads;
    send(16'h2468);
    get(1);
    `CHK("below count", 16'h2468, host.rx_q[0])
    `CHK("no early load", l, loads)
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("sync count", 4'h1, rd[5:2])
    send(16'h8abc);
    `CHK("data dac", 16'h8abc, DAC_DATA)
    `CHK("data load", l + 1, loads)
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("count cleared", 4'h0, rd[5:2])
    adc(16'h4321);
    `CHK("data sample", 16'h4321, host.rx_q[0])
    `CHK("valid flag", 1'b1, SAMPLE_VALID)
  endtask : t_data

  task automatic t_rearm;
    @(posedge CLOCK);
    ARST_N <= 1'b0;
    repeat (3) @(posedge CLOCK);
    ARST_N <= 1'b1;
    apb(1'b0, OFS_STATUS, 32'h0);
    `CHK("status after reset", 32'h0, rd)
    `CHK("dac after reset", 16'h0000, DAC_DATA)
  endtask : t_rearm

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  // Main sequence after a three-cycle reset.
  initial begin
    repeat (3) @(posedge CLOCK);
    ARST_N <= 1'b1;
    t_reset();
    t_regs();
    t_program();
    t_mixed();
    t_data();
    t_rearm();
    wrap_up();
  end

  // Watchdog well past the several hundred cycles the sequence needs.
  initial begin
    #150000;
    fail_count++;
    wrap_up();
  end
endmodule : testbench
